// ### rtl/bis_button_state.sv
`timescale 1ns/1ps
`default_nettype none
`include "bis_defs.svh"

// Notes on behaviour
// - Eleven buttons, each either pressed or released.
// - Each button runs momentary, toggle, or radio group one to five.
// - Interaction state drives the button light and its action trigger.
// - Momentary mode fires the action on press.
// - Momentary press sets state true, release sets it false.
// - Toggle press inverts state; release leaves it alone.
// - Radio press sets own state, clears other group members; release does nothing.
// - Five groups; one group per button; a group may hold all eleven.
// - Rotary steps raise or lower volume within zero to sixteen.
// - Reaching a volume value flagged as condition fires its action.
// - Each knob press inverts the mute flag.
// - Custom scheme: knob press and release give events instead of mute.
// - Three general pins, each with an input or output direction bit.
// - Output pins are driven push-pull to the programmed level.
module bis_button_state #(
    parameter int NB      = `BIS_NUM_BTN,
    parameter int NG      = `BIS_NUM_GRP,
    parameter int NGPIO   = `BIS_NUM_GPIO,
    parameter int DEB_CYC = `BIS_DEBOUNCE_CYC
)(
    // Clock, reset, enable
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     en_i,
    // Front panel contacts and encoder steps
    input  wire logic [NB-1:0]            btn_i,
    input  wire logic                     knob_i,
    input  wire logic                     enc_up_i,
    input  wire logic                     enc_dn_i,
    // Configuration
    input  wire bis_pkg::bis_mode_t [NB-1:0] mode_cfg_i,
    input  wire logic                     custom_scheme_i,
    input  wire logic [`BIS_VOL_MAX:0]    vol_cond_i,
    input  wire logic [NGPIO-1:0]         gpio_dir_i,
    input  wire logic [NGPIO-1:0]         gpio_val_i,
    // General pins, input side
    input  wire logic [NGPIO-1:0]         gpio_in_i,
    // Button state and action events
    output logic [NB-1:0]                 state_o,
    output logic [NB-1:0]                 act_true_o,
    output logic [NB-1:0]                 act_false_o,
    // Rotary
    output logic [4:0]                    vol_o,
    output logic                          vol_hit_o,
    output logic                          mute_o,
    output logic                          knob_press_o,
    output logic                          knob_rel_o,
    // General pins, output side
    output logic [NGPIO-1:0]              gpio_o,
    output logic [NGPIO-1:0]              gpio_oe_o,
    output logic [NGPIO-1:0]              gpio_lvl_o
);
    import bis_pkg::*;

    localparam int KNOB = NB;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Clean events from the contacts; knob sits above the buttons
    bis_evt_if #(.N(NB + 1)) ev ();

    bis_debounce #(
        .N   (NB + 1),
        .CYC (DEB_CYC)
    ) u_deb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (en_i),
        .raw_i ({knob_i, btn_i}),
        .ev    (ev.src)
    );

    logic [NB-1:0]    press;
    logic [NB-1:0]    rel;
    logic [NB-1:0]    win;
    logic [NG-1:0]    grp_hit;
    logic [NB-1:0]    state_ff;
    logic [NB-1:0]    nxt_state;
    logic [NB-1:0]    act_true_ff;
    logic [NB-1:0]    act_false_ff;
    logic [NB-1:0]    nxt_act_true;
    logic [NB-1:0]    nxt_act_false;
    logic [4:0]       vol_ff;
    logic [4:0]       nxt_vol;
    logic             vol_hit_ff;
    logic             nxt_vol_hit;
    logic             mute_ff;
    logic             nxt_mute;
    logic             kp_ff;
    logic             nxt_kp;
    logic             kr_ff;
    logic             nxt_kr;
    logic [NGPIO-1:0] gpio_ff;
    logic [NGPIO-1:0] gpio_oe_ff;
    logic [NGPIO-1:0] gpio_lvl_ff;

    assign press = ev.press[NB-1:0];
    assign rel   = ev.rel[NB-1:0];

    function automatic logic in_grp(bis_mode_t m, int g);
        return m == 3'(`BIS_MODE_RAD1 + g);
    endfunction

    // One winner per group; lowest index wins simultaneous presses,
    // so a group never ends up with two members true
    always_comb begin
        win     = '0;
        grp_hit = '0;
        for (int g = 0; g < NG; g++) begin
            for (int b = 0; b < NB; b++) begin
                if (press[b] && in_grp(mode_cfg_i[b], g)) begin
                    if (!grp_hit[g]) begin
                        win[b] = 1'b1;
                    end
                    grp_hit[g] = 1'b1;
                end
            end
        end
    end

    for (genvar b = 0; b < NB; b++) begin : g_btn
        logic member_hit;

        // Next interaction state by the button's mode
        always_comb begin
            member_hit = 1'b0;
            for (int g = 0; g < NG; g++) begin
                if (in_grp(mode_cfg_i[b], g) && grp_hit[g]) begin
                    member_hit = 1'b1;
                end
            end
            nxt_state[b] = state_ff[b];
            case (mode_cfg_i[b])
                `BIS_MODE_MOM: begin
                    if (press[b]) begin
                        nxt_state[b] = 1'b1;
                    end else if (rel[b]) begin
                        nxt_state[b] = 1'b0;
                    end
                end
                `BIS_MODE_TOG: begin
                    if (press[b]) begin
                        nxt_state[b] = ~state_ff[b];
                    end
                end
                default: begin
                    // Unused code 3'h7 never matches a group and holds
                    if (win[b]) begin
                        nxt_state[b] = 1'b1;
                    end else if (member_hit) begin
                        nxt_state[b] = 1'b0;
                    end
                end
            endcase
        end

        sequence s_mom_press;
            en_i && press[b] && mode_cfg_i[b] == `BIS_MODE_MOM;
        endsequence

        a_mom_press: assert property (s_mom_press |=> state_o[b])
            else $error("momentary press did not set state");
        a_mom_act: assert property (s_mom_press ##0 !state_o[b] |=> act_true_o[b])
            else $error("momentary press did not fire action");
        a_mom_rel: assert property (en_i && rel[b] && mode_cfg_i[b] == `BIS_MODE_MOM
                                    |=> !state_o[b] && act_false_o[b])
            else $error("momentary release did not clear state");
        a_tog_press: assert property (en_i && press[b] && mode_cfg_i[b] == `BIS_MODE_TOG
                                      |=> state_o[b] != $past(state_o[b]))
            else $error("toggle press did not invert state");
        a_tog_rel: assert property (en_i && rel[b] && mode_cfg_i[b] == `BIS_MODE_TOG
                                    |=> $stable(state_o[b]))
            else $error("toggle release changed state");
        a_radio_win: assert property (en_i && win[b] |=> state_o[b])
            else $error("radio press did not set state");
        a_radio_clr: assert property (en_i && member_hit && !win[b] |=> !state_o[b])
            else $error("radio member not cleared by group press");
    end

    // Action events follow each change of interaction state
    always_comb begin
        nxt_act_true  = nxt_state & ~state_ff;
        nxt_act_false = ~nxt_state & state_ff;
    end

    // Rotary: volume, condition hit, mute or custom knob events
    always_comb begin
        nxt_vol = vol_ff;
        if (enc_up_i && !enc_dn_i && vol_ff != `BIS_VOL_MAX) begin
            nxt_vol = vol_ff + 5'h01;
        end else if (enc_dn_i && !enc_up_i && vol_ff != `BIS_VOL_MIN) begin
            nxt_vol = vol_ff - 5'h01;
        end
        // Fires only on arrival, not while parked at the value
        nxt_vol_hit = (nxt_vol != vol_ff) && vol_cond_i[nxt_vol];
        nxt_mute    = mute_ff ^ (ev.press[KNOB] && !custom_scheme_i);
        nxt_kp      = ev.press[KNOB] && custom_scheme_i;
        nxt_kr      = ev.rel[KNOB] && custom_scheme_i;
    end

    // All state registered; clock enable low freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= '0;
            act_true_ff  <= '0;
            act_false_ff <= '0;
            vol_ff       <= `BIS_VOL_RST;
            vol_hit_ff   <= 1'b0;
            mute_ff      <= 1'b0;
            kp_ff        <= 1'b0;
            kr_ff        <= 1'b0;
            gpio_ff      <= '0;
            gpio_oe_ff   <= '0;
            gpio_lvl_ff  <= '0;
        end else if (en_i) begin
            state_ff     <= nxt_state;
            act_true_ff  <= nxt_act_true;
            act_false_ff <= nxt_act_false;
            vol_ff       <= nxt_vol;
            vol_hit_ff   <= nxt_vol_hit;
            mute_ff      <= nxt_mute;
            kp_ff        <= nxt_kp;
            kr_ff        <= nxt_kr;
            gpio_ff      <= gpio_val_i;
            gpio_oe_ff   <= gpio_dir_i;
            gpio_lvl_ff  <= gpio_in_i;
        end
    end

    assign state_o      = state_ff;
    assign act_true_o   = act_true_ff;
    assign act_false_o  = act_false_ff;
    assign vol_o        = vol_ff;
    assign vol_hit_o    = vol_hit_ff;
    assign mute_o       = mute_ff;
    assign knob_press_o = kp_ff;
    assign knob_rel_o   = kr_ff;
    assign gpio_o       = gpio_ff;
    assign gpio_oe_o    = gpio_oe_ff;
    assign gpio_lvl_o   = gpio_lvl_ff;

    sequence s_knob_mute;
        en_i && ev.press[KNOB] && !custom_scheme_i;
    endsequence

    sequence s_knob_custom;
        en_i && ev.press[KNOB] && custom_scheme_i;
    endsequence

    a_vol_up: assert property (en_i && enc_up_i && !enc_dn_i && vol_o < `BIS_VOL_MAX
                               |=> vol_o == $past(vol_o) + 5'h01)
        else $error("volume did not step up by one");
    a_vol_sat: assert property (en_i && enc_up_i && !enc_dn_i && vol_o == `BIS_VOL_MAX
                                |=> vol_o == `BIS_VOL_MAX)
        else $error("volume passed its upper end");
    a_vol_floor: assert property (en_i && enc_dn_i && !enc_up_i && vol_o == `BIS_VOL_MIN
                                  |=> vol_o == `BIS_VOL_MIN)
        else $error("volume passed its lower end");
    a_vol_dn: assert property (en_i && enc_dn_i && !enc_up_i && vol_o > `BIS_VOL_MIN
                               |=> vol_o == $past(vol_o) - 5'h01)
        else $error("volume did not step down by one");
    a_vol_hit: assert property (en_i && nxt_vol != vol_o && vol_cond_i[nxt_vol]
                                |=> vol_hit_o && vol_cond_i[vol_o])
        else $error("volume condition reached without event");
    a_mute_tog: assert property (s_knob_mute |=> mute_o != $past(mute_o))
        else $error("knob press did not invert mute");
    a_knob_evt: assert property (s_knob_custom |=> knob_press_o && $stable(mute_o))
        else $error("custom knob press wrong");
    a_knob_rel: assert property (en_i && ev.rel[KNOB] && custom_scheme_i |=> knob_rel_o)
        else $error("custom knob release gave no event");
    a_gpio_drv: assert property (en_i |=> gpio_oe_o == $past(gpio_dir_i)
                                 && gpio_o == $past(gpio_val_i))
        else $error("pin drive does not follow direction and level");

endmodule // bis_button_state

`default_nettype wire

// ### rtl/bis_defs.svh
`ifndef BIS_DEFS_SVH
`define BIS_DEFS_SVH

// Sizes of the panel
`define BIS_NUM_BTN      11
`define BIS_NUM_GRP      5
`define BIS_NUM_GPIO     3

// Volume range and reset value
`define BIS_VOL_MIN      5'h00
`define BIS_VOL_MAX      5'h10
`define BIS_VOL_RST      5'h00

// Operation mode codes; radio group g (0..4) is BIS_MODE_RAD1 + g
`define BIS_MODE_MOM     3'h0
`define BIS_MODE_TOG     3'h1
`define BIS_MODE_RAD1    3'h2

// Timing: clock rate and debounce settle time
`define BIS_CLK_MHZ      125
`define BIS_DEBOUNCE_US  5000
`define BIS_DEBOUNCE_CYC (`BIS_DEBOUNCE_US * `BIS_CLK_MHZ)

`endif

// ### rtl/bis_pkg.sv
package bis_pkg;

    // Per-button operation mode code
    typedef logic [2:0] bis_mode_t;

endpackage

// ### rtl/bis_evt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bis_evt_if #(
    parameter int N = 12
);
    logic [N-1:0] lvl;
    logic [N-1:0] press;
    logic [N-1:0] rel;

    modport src (output lvl, output press, output rel);
    modport dst (input lvl, input press, input rel);
endinterface

`default_nettype wire

// ### rtl/bis_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "bis_defs.svh"

module bis_debounce #(
    parameter int N   = `BIS_NUM_BTN + 1,
    parameter int CYC = `BIS_DEBOUNCE_CYC
)(
    // Clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         en_i,
    // Raw contacts, high while pressed
    input  wire logic [N-1:0] raw_i,
    // Clean levels and edge pulses
    bis_evt_if.src            ev
);
    localparam int CW = $clog2(CYC + 1);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    for (genvar i = 0; i < N; i++) begin : g_in
        logic          s1_ff;
        logic          s2_ff;
        logic          stab_ff;
        logic          pr_ff;
        logic          rl_ff;
        logic [CW-1:0] cnt_ff;
        logic          nxt_stab;
        logic          nxt_pr;
        logic          nxt_rl;
        logic [CW-1:0] nxt_cnt;

        // Accept a new level only after it held for CYC cycles
        always_comb begin
            nxt_stab = stab_ff;
            nxt_pr   = 1'b0;
            nxt_rl   = 1'b0;
            nxt_cnt  = '0;
            if (s2_ff != stab_ff) begin
                if (cnt_ff == CW'(CYC - 1)) begin
                    nxt_stab = s2_ff;
                    nxt_pr   = s2_ff;
                    nxt_rl   = ~s2_ff;
                end else begin
                    nxt_cnt  = cnt_ff + CW'(1);
                end
            end
        end

        // Two-stage sync; s1 feeds only s2 to keep metastability contained
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_ff   <= 1'b0;
                s2_ff   <= 1'b0;
                stab_ff <= 1'b0;
                pr_ff   <= 1'b0;
                rl_ff   <= 1'b0;
                cnt_ff  <= '0;
            end else if (en_i) begin
                s1_ff   <= raw_i[i];
                s2_ff   <= s1_ff;
                stab_ff <= nxt_stab;
                pr_ff   <= nxt_pr;
                rl_ff   <= nxt_rl;
                cnt_ff  <= nxt_cnt;
            end
        end

        assign ev.lvl[i]   = stab_ff;
        assign ev.press[i] = pr_ff;
        assign ev.rel[i]   = rl_ff;

        a_deb_single: assert property (en_i && pr_ff |=> !pr_ff)
            else $error("press event lasted more than one cycle");
        a_deb_edge: assert property (en_i && (pr_ff || rl_ff) |-> stab_ff == pr_ff)
            else $error("edge event disagrees with clean level");
    end

endmodule // bis_debounce

`default_nettype wire

// ### dv/bis_user.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural front-panel user: moves contacts, turns the encoder
module bis_user #(
    parameter int HOLD = 9
)(
    // Clock
    input  wire logic        clk_i,
    // Contacts (bit 11 is the knob) and encoder steps
    output var  logic [11:0] contact_o,
    output var  logic        up_o,
    output var  logic        dn_o
);
    initial begin
        contact_o = 12'h000;
        up_o = 1'b0;
        dn_o = 1'b0;
    end

    // Move one contact and dwell past the debounce time
    task automatic set_contact(input int idx, input logic lvl);
        @(negedge clk_i);
        contact_o[idx] = lvl;
        repeat (HOLD) @(negedge clk_i);
    endtask

    // Contact chatter shorter than the debounce time
    task automatic bounce(input int idx);
        @(negedge clk_i);
        contact_o[idx] = ~contact_o[idx];
        @(negedge clk_i);
        contact_o[idx] = ~contact_o[idx];
        repeat (HOLD) @(negedge clk_i);
    endtask

    // One encoder pulse; both high means no step
    task automatic step(input logic u, input logic d);
        @(negedge clk_i);
        up_o = u;
        dn_o = d;
        @(negedge clk_i);
        up_o = 1'b0;
        dn_o = 1'b0;
    endtask
endmodule // bis_user

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bis_defs.svh"

module tb_top;
    import bis_pkg::*;
    // Short debounce keeps the run brief
    localparam int DEB = 3;

    logic                clk_i, rst_i, en_i, custom;
    logic [11:0]         contact;
    logic                up, dn;
    bis_mode_t [10:0]    mode_cfg;
    logic [16:0]         vol_cond;
    logic [2:0]          gdir, gval, gin, gpio_o, gpio_oe_o, gpio_lvl_o;
    logic [10:0]         state_o, act_true_o, act_false_o;
    logic [4:0]          vol_o;
    logic                vol_hit_o, mute_o, knob_press_o, knob_rel_o;
    int                  fails = 0, checks = 0;
    int                  n_at[11], n_af[11], n_hit = 0, n_kp = 0, n_kr = 0;

    bis_user #(.HOLD(DEB + 6)) u_user (
        .clk_i     (clk_i),
        .contact_o (contact),
        .up_o      (up),
        .dn_o      (dn)
    );

    bis_button_state #(.DEB_CYC(DEB)) dut (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .en_i            (en_i),
        .btn_i           (contact[10:0]),
        .knob_i          (contact[11]),
        .enc_up_i        (up),
        .enc_dn_i        (dn),
        .mode_cfg_i      (mode_cfg),
        .custom_scheme_i (custom),
        .vol_cond_i      (vol_cond),
        .gpio_dir_i      (gdir),
        .gpio_val_i      (gval),
        .gpio_in_i       (gin),
        .state_o         (state_o),
        .act_true_o      (act_true_o),
        .act_false_o     (act_false_o),
        .vol_o           (vol_o),
        .vol_hit_o       (vol_hit_o),
        .mute_o          (mute_o),
        .knob_press_o    (knob_press_o),
        .knob_rel_o      (knob_rel_o),
        .gpio_o          (gpio_o),
        .gpio_oe_o       (gpio_oe_o),
        .gpio_lvl_o      (gpio_lvl_o)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Tally pulses mid-cycle, where each one-cycle pulse is seen exactly once
    always @(negedge clk_i) begin
        if (!rst_i) begin
            for (int b = 0; b < 11; b++) begin
                n_at[b] += act_true_o[b];
                n_af[b] += act_false_o[b];
            end
            n_hit += vol_hit_o;
            n_kp += knob_press_o;
            n_kr += knob_rel_o;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Momentary: level follows contact, chatter is ignored
    task automatic t_momentary();
        mode_cfg[0] = `BIS_MODE_MOM;
        u_user.set_contact(0, 1'b1);
        chk(state_o[0], 1'b1);
        chk(n_at[0], 1);
        u_user.set_contact(0, 1'b0);
        chk(state_o[0], 1'b0);
        chk(n_af[0], 1);
        u_user.bounce(0);
        chk(state_o[0], 1'b0);
        chk(n_at[0], 1);
        $display("Scenario momentary finished");
    endtask

    // Toggle: press inverts, release holds
    task automatic t_toggle();
        mode_cfg[1] = `BIS_MODE_TOG;
        for (int i = 0; i < 2; i++) begin
            u_user.set_contact(1, 1'b1);
            chk(state_o[1], i == 0);
            u_user.set_contact(1, 1'b0);
            chk(state_o[1], i == 0);
        end
        $display("Scenario toggle finished");
    endtask

    // Radio: every group, a neighbour group left alone
    task automatic t_radio();
        for (int g = 0; g < 5; g++) begin
            mode_cfg[2] = `BIS_MODE_RAD1 + 3'(g);
            mode_cfg[3] = `BIS_MODE_RAD1 + 3'(g);
            mode_cfg[4] = `BIS_MODE_RAD1 + 3'((g + 1) % 5);
            u_user.set_contact(4, 1'b1);
            u_user.set_contact(4, 1'b0);
            u_user.set_contact(2, 1'b1);
            chk(state_o[4:2], 3'h5);
            u_user.set_contact(2, 1'b0);
            chk(state_o[4:2], 3'h5);
            u_user.set_contact(3, 1'b1);
            u_user.set_contact(3, 1'b0);
            chk(state_o[4:2], 3'h6);
        end
        $display("Scenario radio finished");
    endtask

    // Volume: climb past the top, both-at-once, descend past zero
    task automatic t_volume();
        vol_cond = 17'h10008;
        for (int i = 1; i <= 18; i++) begin
            u_user.step(1'b1, 1'b0);
            chk(vol_o, (i > 16) ? 16 : i);
        end
        u_user.step(1'b1, 1'b1);
        chk(vol_o, 5'h10);
        for (int i = 15; i >= -1; i--) begin
            u_user.step(1'b0, 1'b1);
            chk(vol_o, (i < 0) ? 0 : i);
        end
        repeat (2) @(negedge clk_i);
        chk(n_hit, 3);
        $display("Scenario volume finished");
    endtask

    // Knob: mute toggles, custom scheme gives events instead
    task automatic t_knob();
        for (int i = 0; i < 2; i++) begin
            u_user.set_contact(11, 1'b1);
            u_user.set_contact(11, 1'b0);
            chk(mute_o, i == 0);
        end
        chk(n_kp + n_kr, 0);
        custom = 1'b1;
        u_user.set_contact(11, 1'b1);
        chk(n_kp, 1);
        chk(n_kr, 0);
        u_user.set_contact(11, 1'b0);
        chk({mute_o, n_kr[0]}, 2'h1);
        custom = 1'b0;
        $display("Scenario knob finished");
    endtask

    // General pins: all direction and level patterns
    task automatic t_gpio();
        for (int p = 0; p < 8; p++) begin
            gdir = 3'(p);
            gval = 3'(p) ^ 3'h5;
            gin = 3'(7 - p);
            repeat (2) @(negedge clk_i);
            chk(gpio_oe_o, gdir);
            chk(gpio_o & gdir, gval & gdir);
            chk(gpio_lvl_o, gin);
        end
        $display("Scenario gpio finished");
    endtask

    // Code 7 is no mode at all: presses leave state alone
    task automatic t_inert();
        mode_cfg[5] = 3'h7;
        u_user.set_contact(5, 1'b1);
        u_user.set_contact(5, 1'b0);
        chk(state_o[5], 1'b0);
        chk(n_at[5], 0);
        $display("Scenario inert finished");
    endtask

    // Enable low freezes debouncer and volume; the held press lands once raised
    task automatic t_enable();
        en_i = 1'b0;
        u_user.set_contact(0, 1'b1);
        u_user.step(1'b1, 1'b0);
        chk(state_o[0], 1'b0);
        chk(vol_o, 5'h00);
        en_i = 1'b1;
        repeat (9) @(negedge clk_i);
        chk(state_o[0], 1'b1);
        chk(n_at[0], 2);
        u_user.set_contact(0, 1'b0);
        chk(state_o[0], 1'b0);
        chk(n_af[0], 2);
        $display("Scenario enable finished");
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        en_i = 1'b1;
        custom = 1'b0;
        mode_cfg = {11{`BIS_MODE_MOM}};
        vol_cond = 17'h00000;
        gdir = 3'h0;
        gval = 3'h0;
        gin = 3'h0;
        for (int b = 0; b < 11; b++) begin
            n_at[b] = 0;
            n_af[b] = 0;
        end
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        chk({state_o, vol_o, mute_o, gpio_oe_o}, 0);
        t_momentary();
        t_toggle();
        t_radio();
        t_volume();
        t_knob();
        t_gpio();
        t_inert();
        t_enable();
        final_report();
    end
endmodule // tb_top

`default_nettype wire
